// >>> logic/stc_pkg.sv
// Summary of operation
// - Direction qualifier: 00 none, 01 only up, 10 only down, 11 any direction.
// - Equality comparator raises a match when counter equals active compare value.
// - Compare value double buffered; shadow moves to active on secondary shadow pulse.
// - Hardware changes the compare state only while the secondary timer runs.
// - State set on the timer clock after a compare match.
// - State set on next timer clock after zero match together with compare match.
// - State cleared on next timer clock after zero match without compare match.
// - Software set forces the compare state; software clear loses to a hardware or software set in the same cycle.
// - One pin PWM output and one separate internal modulation signal.
// - Pin and modulation active states chosen by independent polarity controls.
// - Active compare register is read-only, changed only by shadow transfer.
// - Shadow register is read/write and copied to active on every transfer.
// - Control bit 13 shows secondary shadow transfer requested.
// - Control bit 12 is the secondary run flag, software set/clear, single-shot clear.
// - Control bit 11 enables extra divide-by-256 in secondary clock path.
// - Bits 10:8 divide secondary clock by two to the field value.
// - Control bit 7 selects primary edge-aligned (0) or center-aligned (1).
// - Control bit 6 shows primary direction, 0 up, 1 down, read-only.
// - Control bit 5 shows primary shadow transfer requested.
// - Control bit 4 is primary run flag, software set/clear, single-shot clear.
// - Bit 3 primary extra divide-by-256; bits 2:0 primary clock divide exponent.
// - Timer control register resets to all zeros.
// - Requested transfer pulses on wrap after period match or while stopped.
// - Each transfer request bit clears when its shadow transfer happens.
// - Clock select and prescaler writes act only while that timer is stopped.
// - Concurrent set and clear on a run flag leaves it unchanged.
package stc_pkg;
  localparam logic [15:0] ADDR_CTRL = 16'he8ac;
  localparam logic [15:0] ADDR_CMP_ACT = 16'he8b0;
  localparam logic [15:0] ADDR_CMP_SHD = 16'he8b4;
  localparam logic [15:0] ADDR_CMD = 16'he8b8;
  localparam logic [15:0] ADDR_CFG = 16'he8bc;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [9:0] CFG_RESET = 10'h000;
  localparam int CTRL_MODE = 7;
  localparam int CTRL_PRE12 = 3;
  localparam int CTRL_PRE13 = 11;
  localparam int CTRL_CLK12_LSB = 0;
  localparam int CTRL_CLK13_LSB = 8;
  localparam int CMD_RUN12_SET = 0;
  localparam int CMD_RUN12_CLR = 1;
  localparam int CMD_PRIMARY_TRANSFER_REQUEST_REQ = 2;
  localparam int CMD_PRIMARY_TRANSFER_REQUEST_DIS = 3;
  localparam int CMD_RUN13_SET = 4;
  localparam int CMD_RUN13_CLR = 5;
  localparam int CMD_SECONDARY_TRANSFER_REQUEST_REQ = 6;
  localparam int CMD_SECONDARY_TRANSFER_REQUEST_DIS = 7;
  localparam int CMD_STATE_SET = 8;
  localparam int CMD_STATE_CLR = 9;
  localparam int CFG_SS12 = 0;
  localparam int CFG_SS13 = 1;
  localparam int CFG_TEC_LSB = 2;
  localparam int CFG_TED_LSB = 5;
  localparam int CFG_PIN_POL = 8;
  localparam int CFG_MOD_POL = 9;
  localparam int CFG_STATE = 15;
  localparam logic [3:0] EXTRA_SHIFT = 4'h8;
  typedef enum logic [1:0] {
    TED_NONE = 2'b00,
    TED_UP = 2'b01,
    TED_DOWN = 2'b10,
    TED_ANY = 2'b11
  } stc_ted_e;
  typedef enum logic [2:0] {
    TEC_NONE = 3'b000,
    TEC_CMP0 = 3'b001,
    TEC_CMP1 = 3'b010,
    TEC_CMP2 = 3'b011,
    TEC_CMP_ANY = 3'b100,
    TEC_PERIOD = 3'b101,
    TEC_ZERO_UP = 3'b110,
    TEC_HALL = 3'b111
  } stc_tec_e;
endpackage

// >>> logic/stc_compare_ctrl.sv
`timescale 1ns/100ps
module stc_compare_ctrl (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [15:0] secondary_count_i,
  input wire logic secondary_zero_match_i,
  input wire logic secondary_period_wrap_i,
  input wire logic primary_direction_i,
  input wire logic [2:0] primary_cmp_event_i,
  input wire logic primary_period_match_i,
  input wire logic primary_zero_match_up_i,
  input wire logic hall_change_i,
  input wire logic primary_single_shot_end_i,
  input wire logic primary_shadow_done_i,
  output logic secondary_run_flag_o,
  output logic primary_run_flag_o,
  output logic [2:0] secondary_clock_select_o,
  output logic secondary_extra_prescale_o,
  output logic [2:0] primary_clock_select_o,
  output logic primary_extra_prescale_o,
  output logic primary_count_mode_o,
  output logic primary_transfer_request_o,
  output logic primary_single_shot_enable_o,
  output logic secondary_tick_o,
  output logic secondary_shadow_pulse_o,
  output logic single_shot_end_pulse_o,
  output logic compare_match_pulse_o,
  output logic [15:0] compare_value_active_o,
  output logic compare_state_flag_o,
  output logic pwm_pin_output_o,
  output logic modulation_output_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic run13;
  logic run12;
  logic secondary_transfer_request;
  logic primary_transfer_request;
  logic pre13;
  logic pre12;
  logic [2:0] clk13;
  logic [2:0] clk12;
  logic mode12;
  logic [15:0] cmp_active;
  logic [15:0] cmp_shadow;
  logic [9:0] cfg;
  logic state;
  logic [14:0] pscnt;
  logic [31:0] rdata_q;
  logic pin_q;
  logic mod_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire hit_ctrl = paddr_i == stc_pkg::ADDR_CTRL;
  wire hit_act = paddr_i == stc_pkg::ADDR_CMP_ACT;
  wire hit_shd = paddr_i == stc_pkg::ADDR_CMP_SHD;
  wire hit_cmd = paddr_i == stc_pkg::ADDR_CMD;
  wire hit_cfg = paddr_i == stc_pkg::ADDR_CFG;
  wire hit = hit_ctrl | hit_act | hit_shd | hit_cmd | hit_cfg;
  wire wr = access & pwrite_i & hit;
  wire [15:0] wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  wire [15:0] wd = pwdata_i[15:0] & wmask;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_shd = wr & hit_shd;
  wire wr_cfg = wr & hit_cfg;
  wire wr_cmd = wr & hit_cmd;

  // Command bits are pulses; they never read back
  wire cmd_run12_set = wr_cmd & wd[stc_pkg::CMD_RUN12_SET];
  wire cmd_run12_clr = wr_cmd & wd[stc_pkg::CMD_RUN12_CLR];
  wire cmd_primary_transfer_request_req = wr_cmd & wd[stc_pkg::CMD_PRIMARY_TRANSFER_REQUEST_REQ];
  wire cmd_primary_transfer_request_dis = wr_cmd & wd[stc_pkg::CMD_PRIMARY_TRANSFER_REQUEST_DIS];
  wire cmd_run13_set = wr_cmd & wd[stc_pkg::CMD_RUN13_SET];
  wire cmd_run13_clr = wr_cmd & wd[stc_pkg::CMD_RUN13_CLR];
  wire cmd_secondary_transfer_request_req = wr_cmd & wd[stc_pkg::CMD_SECONDARY_TRANSFER_REQUEST_REQ];
  wire cmd_secondary_transfer_request_dis = wr_cmd & wd[stc_pkg::CMD_SECONDARY_TRANSFER_REQUEST_DIS];
  wire cmd_state_set = wr_cmd & wd[stc_pkg::CMD_STATE_SET];
  wire cmd_state_clr = wr_cmd & wd[stc_pkg::CMD_STATE_CLR];

  wire [15:0] ctrl_rd = {2'b00, secondary_transfer_request, run13, pre13, clk13,
                         mode12, primary_direction_i,
                         primary_transfer_request, run12, pre12, clk12};
  wire [15:0] cfg_rd = {state, 5'h00, cfg};
  wire [15:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_act ? cmp_active :
                       hit_shd ? cmp_shadow :
                       hit_cfg ? cfg_rd : 16'h0000;

  assign pready_o = access;
  assign pslverr_o = access & ~hit;
  assign prdata_o = rdata_q;

  // Read data sampled in setup so the access phase needs no wait state
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      rdata_q <= {16'h0000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // Secondary prescaler
  // ---------------------------------------------------------------
  wire [3:0] shift13 = {1'b0, clk13} + (pre13 ? stc_pkg::EXTRA_SHIFT : 4'h0);
  wire [14:0] psmask = ~(15'h7fff << shift13);
  // Prescaler cleared while stopped gives reproducible start delays
  wire tick = run13 & ((pscnt & psmask) == psmask);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run13) begin
      pscnt <= 15'h0000;
    end else begin
      pscnt <= pscnt + 15'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Trigger from primary timer events
  // ---------------------------------------------------------------
  wire [2:0] tec = cfg[stc_pkg::CFG_TEC_LSB +: 3];
  wire [1:0] ted = cfg[stc_pkg::CFG_TED_LSB +: 2];
  wire ev_sel = (tec == stc_pkg::TEC_CMP0) ? primary_cmp_event_i[0] :
                (tec == stc_pkg::TEC_CMP1) ? primary_cmp_event_i[1] :
                (tec == stc_pkg::TEC_CMP2) ? primary_cmp_event_i[2] :
                (tec == stc_pkg::TEC_CMP_ANY) ? |primary_cmp_event_i :
                (tec == stc_pkg::TEC_PERIOD) ? primary_period_match_i :
                (tec == stc_pkg::TEC_ZERO_UP) ? primary_zero_match_up_i :
                (tec == stc_pkg::TEC_HALL) ? hall_change_i : 1'b0;
  wire dir_ok = (ted == stc_pkg::TED_UP && !primary_direction_i) ||
                (ted == stc_pkg::TED_DOWN && primary_direction_i) ||
                (ted == stc_pkg::TED_ANY);
  wire trig = ev_sel & dir_ok;

  // ---------------------------------------------------------------
  // Run flags
  // ---------------------------------------------------------------
  wire ss_end13 = run13 & cfg[stc_pkg::CFG_SS13] & secondary_period_wrap_i;
  wire set13 = cmd_run13_set | trig;
  wire clr13 = cmd_run13_clr | ss_end13;
  wire set12 = cmd_run12_set;
  wire clr12 = cmd_run12_clr | primary_single_shot_end_i;
  wire next_run13 = (set13 ^ clr13) ? set13 : run13;
  wire next_run12 = (set12 ^ clr12) ? set12 : run12;

  // ---------------------------------------------------------------
  // Shadow transfer requests
  // ---------------------------------------------------------------
  wire st13 = secondary_transfer_request & (secondary_period_wrap_i | ~run13);
  // Request wins over a transfer in the same cycle; request with disable leaves the bit unchanged
  wire next_secondary_transfer_request = cmd_secondary_transfer_request_req ? ~cmd_secondary_transfer_request_dis | secondary_transfer_request :
                    (cmd_secondary_transfer_request_dis | st13) ? 1'b0 : secondary_transfer_request;
  wire next_primary_transfer_request = cmd_primary_transfer_request_req ? ~cmd_primary_transfer_request_dis | primary_transfer_request :
                    (cmd_primary_transfer_request_dis | primary_shadow_done_i) ? 1'b0 : primary_transfer_request;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      run13 <= 1'b0;
      run12 <= 1'b0;
      secondary_transfer_request <= 1'b0;
      primary_transfer_request <= 1'b0;
    end else begin
      run13 <= next_run13;
      run12 <= next_run12;
      secondary_transfer_request <= next_secondary_transfer_request;
      primary_transfer_request <= next_primary_transfer_request;
    end
  end

  // ---------------------------------------------------------------
  // Control and configuration writes
  // ---------------------------------------------------------------
  wire [15:0] cw = (ctrl_rd & ~wmask) | wd;
  wire next_mode12 = wr_ctrl ? cw[stc_pkg::CTRL_MODE] : mode12;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pre13 <= 1'b0;
      clk13 <= 3'h0;
      pre12 <= 1'b0;
      clk12 <= 3'h0;
      mode12 <= 1'b0;
    end else begin
      mode12 <= next_mode12;
      if (wr_ctrl && !run13) begin
        pre13 <= cw[stc_pkg::CTRL_PRE13];
        clk13 <= cw[stc_pkg::CTRL_CLK13_LSB +: 3];
      end
      if (wr_ctrl && !run12) begin
        pre12 <= cw[stc_pkg::CTRL_PRE12];
        clk12 <= cw[stc_pkg::CTRL_CLK12_LSB +: 3];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cfg <= stc_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= (cfg & ~wmask[9:0]) | wd[9:0];
    end
  end

  // ---------------------------------------------------------------
  // Compare registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cmp_shadow <= stc_pkg::CMP_RESET;
      cmp_active <= stc_pkg::CMP_RESET;
    end else begin
      if (wr_shd) begin
        cmp_shadow <= (cmp_shadow & ~wmask) | wd;
      end
      if (st13) begin
        cmp_active <= cmp_shadow;
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare state
  // ---------------------------------------------------------------
  wire cm = secondary_count_i == cmp_active;
  // Evaluated on the tick that moves the counter off the matched value
  wire hw_set = tick & cm;
  wire hw_clr = tick & secondary_zero_match_i & ~cm;
  wire next_state = (hw_set | cmd_state_set) ? 1'b1 :
                    (hw_clr | cmd_state_clr) ? 1'b0 : state;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= 1'b0;
      pin_q <= 1'b0;
      mod_q <= 1'b0;
    end else begin
      state <= next_state;
      pin_q <= state ^ cfg[stc_pkg::CFG_PIN_POL];
      mod_q <= state ^ cfg[stc_pkg::CFG_MOD_POL];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign secondary_run_flag_o = run13;
  assign primary_run_flag_o = run12;
  assign secondary_clock_select_o = clk13;
  assign secondary_extra_prescale_o = pre13;
  assign primary_clock_select_o = clk12;
  assign primary_extra_prescale_o = pre12;
  assign primary_count_mode_o = mode12;
  assign primary_transfer_request_o = primary_transfer_request;
  assign primary_single_shot_enable_o = cfg[stc_pkg::CFG_SS12];
  assign secondary_tick_o = tick;
  assign secondary_shadow_pulse_o = st13;
  assign single_shot_end_pulse_o = ss_end13;
  assign compare_match_pulse_o = cm & run13;
  assign compare_value_active_o = cmp_active;
  assign compare_state_flag_o = state;
  assign pwm_pin_output_o = pin_q;
  assign modulation_output_o = mod_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_dir_none_idle: assert property (
    !run13 && ted == stc_pkg::TED_NONE && !cmd_run13_set |=> !run13)
    else $error("run started with no direction selected");
  a_dir_up_start: assert property (
    ev_sel && ted == stc_pkg::TED_UP && !primary_direction_i && !clr13 |=> run13)
    else $error("up trigger did not start timer");
  a_match_sets: assert property (
    tick && cm |=> state)
    else $error("compare match did not set state");
  a_zero_clears: assert property (
    tick && secondary_zero_match_i && !cm && !cmd_state_set |=> !state)
    else $error("zero match did not clear state");
  a_stop_holds: assert property (
    !run13 && !cmd_state_set && !cmd_state_clr |=> $stable(state))
    else $error("state changed while stopped");
  a_shadow_load: assert property (
    st13 |=> cmp_active == $past(cmp_shadow))
    else $error("active compare not loaded");
  a_active_hold: assert property (
    !st13 |=> $stable(cmp_active))
    else $error("active compare changed without transfer");
  a_req_clears: assert property (
    st13 && !cmd_secondary_transfer_request_req |=> !secondary_transfer_request)
    else $error("transfer request not cleared");
  a_clk_locked: assert property (
    run13 |=> $stable(clk13) && $stable(pre13))
    else $error("clock select changed while running");
  a_run_conflict: assert property (
    set13 && clr13 |=> $stable(run13))
    else $error("run flag moved on conflicting commands");
  a_pin_polarity: assert property (
    state && !cfg[stc_pkg::CFG_PIN_POL] ##1 $stable(cfg) |-> pwm_pin_output_o)
    else $error("pin output wrong polarity");

  // Modulation polarity, software commands, zero with match, stopped-timer transfer and single shot
  a_mod_polarity: assert property (
    state && !cfg[stc_pkg::CFG_MOD_POL] ##1 $stable(cfg) |-> modulation_output_o)
    else $error("modulation output wrong polarity");
  a_sw_set: assert property (
    cmd_state_set |=> state)
    else $error("software set did not set state");
  // Hardware set wins over a software clear in the same cycle
  a_sw_clear: assert property (
    cmd_state_clr && !cmd_state_set && !hw_set |=> !state)
    else $error("software clear did not clear state");
  a_zero_with_match: assert property (
    tick && secondary_zero_match_i && cm |=> state)
    else $error("zero match with compare match did not set state");
  a_stopped_xfer: assert property (
    secondary_transfer_request && !run13 |=> cmp_active == $past(cmp_shadow))
    else $error("no transfer while stopped");
  a_single_shot_stop: assert property (
    ss_end13 && !set13 |=> !run13)
    else $error("single shot did not stop timer");

  // Scenarios the bench is expected to reach
  c_state_rise: cover property ($rose(state));
  c_shadow_run: cover property (st13 && run13);
  c_trig_start: cover property (trig && !run13 ##1 run13);
  c_zero_and_match: cover property (tick && secondary_zero_match_i && cm);
  c_single_shot_end: cover property (ss_end13);
endmodule

// >>> verif/stc_timer_model.sv
`timescale 1ns/100ps
module stc_timer_model #(
  parameter logic [15:0] PERIOD = 16'h0028
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  output logic [15:0] count_o,
  output logic zero_o,
  output logic wrap_o
);
  // ----------------------------------------
  // Up counter with period reset
  // ----------------------------------------
  assign zero_o = (count_o == 16'h0000);
  // Wrap flags the cycle whose edge returns the count to zero
  assign wrap_o = run_i & tick_i & (count_o == PERIOD);

  // Count freezes while stopped, so a stopped timer never drifts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 16'h0000;
    end else if (run_i & tick_i) begin
      count_o <= wrap_o ? 16'h0000 : count_o + 16'h0001;
    end
  end
endmodule

// >>> verif/secondary_timer_compare_ctrl_tb_top.sv
`timescale 1ns/100ps
module secondary_timer_compare_ctrl_tb_top;
  logic ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [15:0] paddr_i, secondary_count_i, compare_value_active_o;
  logic [31:0] pwdata_i, prdata_o, r;
  logic secondary_zero_match_i, secondary_period_wrap_i, primary_direction_i;
  logic [2:0] primary_cmp_event_i;
  logic primary_period_match_i, primary_zero_match_up_i, hall_change_i;
  logic primary_single_shot_end_i, primary_shadow_done_i, secondary_run_flag_o, secondary_tick_o;
  logic compare_match_pulse_o, compare_state_flag_o, pwm_pin_output_o, modulation_output_o, e;
  logic [1:0] pv;
  logic primary_run_flag_o, primary_transfer_request_o, primary_single_shot_enable_o, secondary_shadow_pulse_o;
  logic single_shot_end_pulse_o, secondary_extra_prescale_o, primary_extra_prescale_o, primary_count_mode_o;
  logic [2:0] secondary_clock_select_o, primary_clock_select_o;
  int errors, checks_done;

  // ----------------------------------------
  // Design and far-side counter
  // ----------------------------------------
  stc_compare_ctrl dut (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i(4'hf), .prdata_o, .pready_o, .pslverr_o, .secondary_count_i, .secondary_zero_match_i,
    .secondary_period_wrap_i, .primary_direction_i, .primary_cmp_event_i, .primary_period_match_i,
    .primary_zero_match_up_i, .hall_change_i, .primary_single_shot_end_i, .primary_shadow_done_i,
    .secondary_run_flag_o, .primary_run_flag_o, .secondary_clock_select_o,
    .secondary_extra_prescale_o, .primary_clock_select_o, .primary_extra_prescale_o,
    .primary_count_mode_o, .primary_transfer_request_o, .primary_single_shot_enable_o,
    .secondary_tick_o, .secondary_shadow_pulse_o, .single_shot_end_pulse_o, .compare_match_pulse_o,
    .compare_value_active_o, .compare_state_flag_o, .pwm_pin_output_o, .modulation_output_o);
  stc_timer_model #(.PERIOD(16'h0028)) u_model (.clk_i(ref_clk_i), .rst_i(sys_rst_i),
    .run_i(secondary_run_flag_o), .tick_i(secondary_tick_o), .count_o(secondary_count_i),
    .zero_o(secondary_zero_match_i), .wrap_o(secondary_period_wrap_i));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  always #2 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask

  task automatic bit1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Waits for a count value; a miss shows as a count mismatch
  task automatic wt(input logic [15:0] v);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge ref_clk_i);
      #1;
      if (secondary_count_i === v) break;
    end
    chk({16'h0, secondary_count_i}, {16'h0, v});
  endtask

  // Codes 1..7 follow the event select field, 8 single-shot end, 9 shadow done
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    case (k)
      1, 2, 3: primary_cmp_event_i <= 3'h1 << (k - 1);
      4: primary_cmp_event_i <= 3'h4;
      5: primary_period_match_i <= 1'b1;
      6: primary_zero_match_up_i <= 1'b1;
      7: hall_change_i <= 1'b1;
      8: primary_single_shot_end_i <= 1'b1;
      9: primary_shadow_done_i <= 1'b1;
      default: ;
    endcase
    @(posedge ref_clk_i);
    {primary_cmp_event_i, primary_period_match_i, primary_zero_match_up_i} <= 5'h00;
    {hall_change_i, primary_single_shot_end_i, primary_shadow_done_i} <= 3'h0;
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    {ref_clk_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, primary_direction_i} = '0;
    {primary_cmp_event_i, primary_period_match_i, primary_zero_match_up_i, hall_change_i} = '0;
    {primary_single_shot_end_i, primary_shadow_done_i, errors, checks_done} = '0;
    sys_rst_i = 1'b1;
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(stc_pkg::ADDR_CTRL, 32'h0);
    rd(stc_pkg::ADDR_CMP_ACT, 32'h0);
    rd(stc_pkg::ADDR_CMP_SHD, 32'h0);
    bit1(compare_state_flag_o, 1'b0);
    apb(1'b0, 16'he8c0, 32'h0);
    bit1(e, 1'b1);
    wr(stc_pkg::ADDR_CTRL, 32'hffff);
    rd(stc_pkg::ADDR_CTRL, 32'h0f8f);
    chk({23'h0, secondary_extra_prescale_o, secondary_clock_select_o, primary_count_mode_o,
      primary_extra_prescale_o, primary_clock_select_o}, 32'h1ff);
    @(posedge ref_clk_i) primary_direction_i <= 1'b1;
    rd(stc_pkg::ADDR_CTRL, 32'h0fcf);
    @(posedge ref_clk_i) primary_direction_i <= 1'b0;
    wr(stc_pkg::ADDR_CTRL, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_PRIMARY_TRANSFER_REQUEST_REQ);
    rd(stc_pkg::ADDR_CTRL, 32'h20);
    bit1(primary_transfer_request_o, 1'b1);
    pulse(9);
    rd(stc_pkg::ADDR_CTRL, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_RUN12_SET);
    wr(stc_pkg::ADDR_CMD, 32'h3);
    rd(stc_pkg::ADDR_CTRL, 32'h10);
    bit1(primary_run_flag_o, 1'b1);
    wr(stc_pkg::ADDR_CTRL, 32'h85);
    rd(stc_pkg::ADDR_CTRL, 32'h90);
    pulse(8);
    rd(stc_pkg::ADDR_CTRL, 32'h80);
    wr(stc_pkg::ADDR_CTRL, 32'h05);
    rd(stc_pkg::ADDR_CTRL, 32'h05);
    wr(stc_pkg::ADDR_CTRL, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_STATE_SET);
    bit1(compare_state_flag_o, 1'b1);
    for (int p = 0; p < 4; p++) begin
      pv = p[1:0];
      wr(stc_pkg::ADDR_CFG, 32'(p) << 8);
      @(posedge ref_clk_i);
      #1;
      bit1(pwm_pin_output_o, ~pv[0]);
      bit1(modulation_output_o, ~pv[1]);
    end
    wr(stc_pkg::ADDR_CFG, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_STATE_CLR);
    bit1(compare_state_flag_o, 1'b0);
    wr(stc_pkg::ADDR_CMP_SHD, 32'h4);
    rd(stc_pkg::ADDR_CMP_SHD, 32'h4);
    wr(stc_pkg::ADDR_CMP_ACT, 32'h7);
    rd(stc_pkg::ADDR_CMP_ACT, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_SECONDARY_TRANSFER_REQUEST_REQ);
    rd(stc_pkg::ADDR_CMP_ACT, 32'h4);
    rd(stc_pkg::ADDR_CTRL, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_RUN13_SET);
    wt(16'h4);
    bit1(compare_match_pulse_o, 1'b1);
    wt(16'h5);
    bit1(compare_state_flag_o, 1'b1);
    wt(16'h1);
    bit1(compare_state_flag_o, 1'b0);
    // Stopped with count equal to the compare value: state must not move
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_RUN13_CLR);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_STATE_CLR);
    wr(stc_pkg::ADDR_CMP_SHD, {16'h0, secondary_count_i});
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_SECONDARY_TRANSFER_REQUEST_REQ);
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk({16'h0, compare_value_active_o}, {16'h0, secondary_count_i});
    bit1(compare_state_flag_o, 1'b0);
    wr(stc_pkg::ADDR_CMP_SHD, 32'h0);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_SECONDARY_TRANSFER_REQUEST_REQ);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_RUN13_SET);
    wt(16'h1);
    bit1(compare_state_flag_o, 1'b1);
    wt(16'h2);
    wr(stc_pkg::ADDR_CMP_SHD, 32'h3);
    wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_SECONDARY_TRANSFER_REQUEST_REQ);
    rd(stc_pkg::ADDR_CTRL, 32'h3000);
    wt(16'h28);
    bit1(secondary_shadow_pulse_o, 1'b1);
    wt(16'h1);
    chk({16'h0, compare_value_active_o}, 32'h3);
    rd(stc_pkg::ADDR_CTRL, 32'h1000);
    wr(stc_pkg::ADDR_CFG, 32'h3);
    bit1(primary_single_shot_enable_o, 1'b1);
    wt(16'h28);
    bit1(single_shot_end_pulse_o, 1'b1);
    wt(16'h0);
    @(posedge ref_clk_i);
    #1;
    bit1(secondary_run_flag_o, 1'b0);
    for (int t = 0; t < 4; t++) begin
      for (int d = 0; d < 2; d++) begin
        pv = t[1:0];
        @(posedge ref_clk_i) primary_direction_i <= d[0];
        wr(stc_pkg::ADDR_CFG, (32'(t) << 5) | 32'h14);
        pulse(5);
        bit1(secondary_run_flag_o, pv[d]);
        wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_RUN13_CLR);
      end
    end
    @(posedge ref_clk_i) primary_direction_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      wr(stc_pkg::ADDR_CFG, 32'h60 | (32'(k) << 2));
      pulse(k == 0 ? 5 : k);
      bit1(secondary_run_flag_o, k != 0);
      wr(stc_pkg::ADDR_CMD, 32'h1 << stc_pkg::CMD_RUN13_CLR);
    end
    end_of_test();
  end
endmodule
